// [rtl/can_cmd_consts.svh]
// Constants of the CAN command and fault decoder
`ifndef CAN_CMD_CONSTS_SVH
`define CAN_CMD_CONSTS_SVH
`define CAN_ID_REQ_BASE 21'h000c05
`define CAN_ID_RSP_BASE 21'h000c04
`define DLC_WRITE 4'h4
`define DLC_READ 4'h2
`define DLC_REPLY 4'h4
`define CMD_CC 16'h00b0
`define CMD_CV 16'h00b1
`define CMD_CURVE 16'h00b4
`define CMD_UNLOCK 16'h00cf
`define CMD_OPER 16'h0100
`define CMD_MODE 16'h0101
`define CMD_ACV 16'h0102
`define CMD_ACF 16'h0103
`define CMD_FAULT 16'h011e
`define UNLOCK_KEY 16'h574d
`define CURVE_TWO_STAGE 16'h0040
`define MODE_UPS 2'h0
`define MODE_SAVING 2'h1
`define OPER_SW 0
`define OPER_EN 1
`define OPER_CHG 2
`define OPER_RESET 3'h5
`define LOAD_PCT_100 8'h64
`define LOAD_PCT_115 8'h73
`define LOAD_PCT_150 8'h96
`define FLT_OL_LO 0
`define FLT_OL_MID 1
`define FLT_OL_HI 2
`define FLT_LOW_FLAGS 3
`define FLT_HIGH_FLAGS 8
`define FLT_USED 13
`endif

// [rtl/can_cmd_pkg.sv]
// Types shared by the CAN command decoder modules
`default_nettype none
package can_cmd_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_BUSY = 1'b1
	} tx_state_e;
endpackage
`default_nettype wire

// [rtl/reply_if.sv]
// Reply request carrier between decoder and framer
`default_nettype none
interface reply_if;
	import can_cmd_pkg::*;
	logic valid;
	logic ready;
	logic [7:0] addr;
	word_t cmd;
	word_t data;
	modport src(output valid, addr, cmd, data, input ready);
	modport snk(input valid, addr, cmd, data, output ready);
endinterface
`default_nettype wire

// [rtl/reply_framer.sv]
// Builds and holds the reply frame toward the CAN controller
`include "can_cmd_consts.svh"
`default_nettype none
module reply_framer
	import can_cmd_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	reply_if.snk rq,
	input wire logic tx_ready_in,
	output logic tx_valid_out,
	output logic [28:0] tx_id_out,
	output logic [3:0] tx_dlc_out,
	output logic [31:0] tx_data_out
);
	typedef struct packed {
		tx_state_e st;
		logic valid;
		logic [28:0] id;
		logic [31:0] data;
	} frm_s;

	frm_s s_r;
	frm_s s_nxt;

	////////////////////////////////////////////////////////////////////
	// Take a request when idle, hold the frame until the controller
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			TX_IDLE: begin
				if (rq.valid) begin
					s_nxt.st = TX_BUSY;
					s_nxt.valid = 1'b1;
					s_nxt.id = {`CAN_ID_RSP_BASE, rq.addr};
					s_nxt.data = {rq.data, rq.cmd};
				end
			end
			TX_BUSY: begin
				if (tx_ready_in) begin
					s_nxt.st = TX_IDLE;
					s_nxt.valid = 1'b0;
				end
			end
			default: begin
				s_nxt.st = TX_IDLE;
				s_nxt.valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rq.ready = (s_r.st == TX_IDLE);
	assign tx_valid_out = s_r.valid;
	assign tx_id_out = s_r.id;
	assign tx_dlc_out = `DLC_REPLY;
	assign tx_data_out = s_r.data;
endmodule // reply_framer
`default_nettype wire

// [rtl/can_command_fault_decoder.sv]
// Top of the CAN command interpreter and fault word reporter
`include "can_cmd_consts.svh"
`default_nettype none
module can_command_fault_decoder
	import can_cmd_pkg::*;
#(
	parameter word_t CC_RESET = 16'h0000,
	parameter word_t CV_RESET = 16'h0000,
	parameter word_t CURVE_RESET = 16'h0000,
	parameter word_t ACV_RESET = 16'h0000,
	parameter word_t ACF_RESET = 16'h0000,
	parameter logic [1:0] MODE_RESET = 2'h0
)(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] unit_addr_in,
	input wire logic rx_valid_in,
	input wire logic [28:0] rx_id_in,
	input wire logic [3:0] rx_dlc_in,
	input wire logic [31:0] rx_data_in,
	output logic rx_ready_out,
	input wire logic tx_ready_in,
	output logic tx_valid_out,
	output logic [28:0] tx_id_out,
	output logic [3:0] tx_dlc_out,
	output logic [31:0] tx_data_out,
	input wire logic [7:0] load_pct_in,
	input wire logic [9:0] fault_flags_in,
	input wire logic restart_in,
	output logic [15:0] fault_status_word_out,
	output logic ac_output_on_out,
	output logic charger_enable_out,
	output logic energy_saving_out,
	output logic two_stage_charge_out,
	output logic [15:0] charge_current_out,
	output logic [15:0] charge_voltage_out,
	output logic [15:0] output_voltage_out,
	output logic [15:0] output_frequency_out,
	output logic settings_unlocked_out,
	output logic restart_pending_out
);

	////////////////////////////////////////////////////////////////////
	// Refuse reset values the mode field cannot hold
	generate
		if (MODE_RESET[1]) begin : g_bad_mode
			$error("MODE_RESET must be UPS or saving");
		end
	endgenerate

	typedef struct packed {
		logic [7:0] addr_meta;
		logic [7:0] addr_sync;
		word_t cc;
		word_t cv;
		word_t curve;
		word_t acv_stored;
		word_t acf_stored;
		word_t acv_active;
		word_t acf_active;
		logic [2:0] oper;
		logic [1:0] mode;
		logic unlocked;
		logic [12:0] fault;
		logic pend;
		word_t pend_cmd;
		word_t pend_data;
		logic rx_ready;
		logic ac_on;
		logic two_stage;
		logic restart_pend;
	} dec_s;

	localparam dec_s RESET_S = '{
		addr_meta: 8'h00,
		addr_sync: 8'h00,
		cc: CC_RESET,
		cv: CV_RESET,
		curve: CURVE_RESET,
		acv_stored: ACV_RESET,
		acf_stored: ACF_RESET,
		acv_active: ACV_RESET,
		acf_active: ACF_RESET,
		oper: `OPER_RESET,
		mode: MODE_RESET,
		unlocked: 1'b0,
		fault: 13'h0000,
		pend: 1'b0,
		pend_cmd: 16'h0000,
		pend_data: 16'h0000,
		rx_ready: 1'b1,
		ac_on: 1'b1,
		two_stage: 1'b0,
		restart_pend: 1'b0
	};

	dec_s s_r;
	dec_s s_nxt;
	reply_if rq();

	logic id_hit;
	logic take;
	logic wr_acc;
	logic rd_acc;
	word_t rx_cmd;
	word_t rx_wdata;
	word_t rd_val;

	////////////////////////////////////////////////////////////////////
	// Frame decode; payload arrives low byte first in byte 0
	assign rx_cmd = rx_data_in[15:0];
	assign rx_wdata = rx_data_in[31:16];
	// Base and own address both must match
	assign id_hit = (rx_id_in[28:8] == `CAN_ID_REQ_BASE) &&
		(rx_id_in[7:0] == s_r.addr_sync);
	// Extended identifier only; bit timing lives in the controller
	assign take = rx_valid_in && s_r.rx_ready && id_hit;
	assign wr_acc = take && (rx_dlc_in == `DLC_WRITE);
	assign rd_acc = take && (rx_dlc_in == `DLC_READ);

	////////////////////////////////////////////////////////////////////
	// Read value per command; unknown and write-only items read zero
	always_comb begin
		case (rx_cmd)
			`CMD_CC: rd_val = s_r.cc;
			`CMD_CV: rd_val = s_r.cv;
			`CMD_CURVE: rd_val = s_r.curve;
			`CMD_OPER: rd_val = {13'h0000, s_r.oper};
			`CMD_MODE: rd_val = {14'h0000, s_r.mode};
			`CMD_ACV: rd_val = s_r.acv_stored;
			`CMD_ACF: rd_val = s_r.acf_stored;
			`CMD_FAULT: rd_val = {3'h0, s_r.fault};
			default: rd_val = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Next state of the whole decoder
	always_comb begin
		s_nxt = s_r;
		// Address straps come from pins: two flops first
		s_nxt.addr_meta = unit_addr_in;
		s_nxt.addr_sync = s_r.addr_meta;

		// Fault bits are live levels; reads never touch them
		s_nxt.fault[`FLT_OL_LO] = (load_pct_in >= `LOAD_PCT_100) &&
			(load_pct_in < `LOAD_PCT_115);
		s_nxt.fault[`FLT_OL_MID] = (load_pct_in >= `LOAD_PCT_115) &&
			(load_pct_in < `LOAD_PCT_150);
		s_nxt.fault[`FLT_OL_HI] = (load_pct_in >= `LOAD_PCT_150);
		s_nxt.fault[7:`FLT_LOW_FLAGS] = fault_flags_in[4:0];
		s_nxt.fault[12:`FLT_HIGH_FLAGS] = fault_flags_in[9:5];

		// Restart applies stored voltage and frequency
		if (restart_in) begin
			s_nxt.acv_active = s_r.acv_stored;
			s_nxt.acf_active = s_r.acf_stored;
			s_nxt.unlocked = 1'b0;
		end

		// Writes; charge values kept as 0.01-unit counts
		if (wr_acc) begin
			case (rx_cmd)
				`CMD_CC: s_nxt.cc = rx_wdata;
				`CMD_CV: s_nxt.cv = rx_wdata;
				`CMD_CURVE: s_nxt.curve = rx_wdata;
				`CMD_UNLOCK: begin
					if (rx_wdata == `UNLOCK_KEY) begin
						s_nxt.unlocked = 1'b1;
					end
				end
				`CMD_OPER: s_nxt.oper = rx_wdata[2:0];
				`CMD_MODE: begin
					// Reserved codes 10 and 11 are dropped
					if (rx_wdata[15:1] == 15'h0000) begin
						s_nxt.mode = rx_wdata[1:0];
					end
				end
				`CMD_ACV: begin
					if (s_r.unlocked) begin
						s_nxt.acv_stored = rx_wdata;
					end
				end
				`CMD_ACF: begin
					if (s_r.unlocked) begin
						s_nxt.acf_stored = rx_wdata;
					end
				end
				default: begin
				end
			endcase
		end

		// Pending flag shows a stored setting still waits for restart
		s_nxt.restart_pend = (s_nxt.acv_stored != s_nxt.acv_active) ||
			(s_nxt.acf_stored != s_nxt.acf_active);

		// Reply hand-off; a new read overlaps only after the take
		if (s_r.pend && rq.ready) begin
			s_nxt.pend = 1'b0;
		end
		if (rd_acc) begin
			s_nxt.pend = 1'b1;
			s_nxt.pend_cmd = rx_cmd;
			s_nxt.pend_data = rd_val;
		end
		// Stall the receiver until the framer takes the pending reply
		s_nxt.rx_ready = !s_nxt.pend;

		// Switch obeys only with remote enable; else output stays on
		s_nxt.ac_on = s_r.oper[`OPER_EN] ?
			s_r.oper[`OPER_SW] : 1'b1;
		s_nxt.two_stage = (s_r.curve == `CURVE_TWO_STAGE);
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_r <= RESET_S;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reply framing and the registered outputs
	assign rq.valid = s_r.pend;
	assign rq.addr = s_r.addr_sync;
	assign rq.cmd = s_r.pend_cmd;
	assign rq.data = s_r.pend_data;

	reply_framer u_framer (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.rq(rq),
		.tx_ready_in(tx_ready_in),
		.tx_valid_out(tx_valid_out),
		.tx_id_out(tx_id_out),
		.tx_dlc_out(tx_dlc_out),
		.tx_data_out(tx_data_out)
	);

	assign rx_ready_out = s_r.rx_ready;
	assign fault_status_word_out = {3'h0, s_r.fault};
	assign ac_output_on_out = s_r.ac_on;
	assign charger_enable_out = s_r.oper[`OPER_CHG];
	assign energy_saving_out = s_r.mode[0];
	assign two_stage_charge_out = s_r.two_stage;
	assign charge_current_out = s_r.cc;
	assign charge_voltage_out = s_r.cv;
	assign output_voltage_out = s_r.acv_active;
	assign output_frequency_out = s_r.acf_active;
	assign settings_unlocked_out = s_r.unlocked;
	assign restart_pending_out = s_r.restart_pend;

	////////////////////////////////////////////////////////////////////
	// Checks on the decoder's own behaviour
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	property p_overload_band;
		(load_pct_in >= `LOAD_PCT_150) |=>
			fault_status_word_out[2:0] == 3'h4;
	endproperty
	a_overload_band: assert property (p_overload_band)
		else $error("overload band wrong");

	property p_low_flags;
		1 |=> fault_status_word_out[7:3] == $past(fault_flags_in[4:0]);
	endproperty
	a_low_flags: assert property (p_low_flags)
		else $error("low fault flags wrong");

	property p_high_flags;
		1 |=> fault_status_word_out[15:8] ==
			{3'h0, $past(fault_flags_in[9:5])};
	endproperty
	a_high_flags: assert property (p_high_flags)
		else $error("high fault byte wrong");

	property p_reply_frame;
		(rd_acc && rq.ready) |-> ##2 tx_valid_out &&
			tx_id_out[28:8] == `CAN_ID_RSP_BASE &&
			tx_data_out[15:0] == $past(rx_cmd, 2);
	endproperty
	a_reply_frame: assert property (p_reply_frame)
		else $error("reply frame missing or wrong");

	property p_locked_write;
		(wr_acc && rx_cmd == `CMD_ACV && !s_r.unlocked) |=>
			$stable(s_r.acv_stored);
	endproperty
	a_locked_write: assert property (p_locked_write)
		else $error("locked voltage write took effect");

	property p_apply_on_restart;
		!restart_in |=> $stable(output_voltage_out) &&
			$stable(output_frequency_out);
	endproperty
	a_apply_on_restart: assert property (p_apply_on_restart)
		else $error("setting applied without restart");

	property p_remote_switch;
		1 |=> ac_output_on_out ==
			($past(s_r.oper[1]) ? $past(s_r.oper[0]) : 1'b1);
	endproperty
	a_remote_switch: assert property (p_remote_switch)
		else $error("output switch gating wrong");

	property p_saving_mode;
		(wr_acc && rx_cmd == `CMD_MODE && rx_wdata == 16'h0001) |=>
			##0 energy_saving_out;
	endproperty
	a_saving_mode: assert property (p_saving_mode)
		else $error("saving mode not selected");

	property p_two_stage;
		(wr_acc && rx_cmd == `CMD_CURVE &&
			rx_wdata == `CURVE_TWO_STAGE) |-> ##2 two_stage_charge_out;
	endproperty
	a_two_stage: assert property (p_two_stage)
		else $error("two-stage not selected");

	property p_cc_write;
		(wr_acc && rx_cmd == `CMD_CC) |=>
			charge_current_out == $past(rx_wdata);
	endproperty
	a_cc_write: assert property (p_cc_write)
		else $error("current setpoint not stored");

	property p_foreign_addr;
		(!s_r.pend && rx_valid_in &&
			rx_id_in[7:0] != s_r.addr_sync) |=> !s_r.pend;
	endproperty
	a_foreign_addr: assert property (p_foreign_addr)
		else $error("reply to foreign address");

	c_read: cover property (rd_acc ##2 tx_valid_out);
	c_unlock_write: cover property (s_r.unlocked && wr_acc &&
		rx_cmd == `CMD_ACV);
	c_restart: cover property (restart_pending_out ##1 restart_in);
	c_switch_off: cover property (!ac_output_on_out);
endmodule // can_command_fault_decoder
`default_nettype wire

// [verification/can_master_model.sv]
// Behavioural CAN master model facing the decoder frame ports
`default_nettype none
module can_master_model (
	input wire logic ref_clk_in,
	input wire logic rx_ready_in,
	input wire logic stall_in,
	output logic rx_valid_out,
	output logic [28:0] rx_id_out,
	output logic [3:0] rx_dlc_out,
	output logic [31:0] rx_data_out,
	output logic tx_ready_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Quiet bus at time zero
	initial begin
		rx_valid_out = 1'b0;
		rx_id_out = 29'h0;
		rx_dlc_out = 4'h0;
		rx_data_out = 32'h0;
		tx_ready_out = 1'b1;
	end

	// Reply acceptance; stalls make the framer hold its frame
	always @(posedge ref_clk_in) begin
		tx_ready_out <= !stall_in;
	end

	////////////////////////////////////////////////////////////////////////
	// One request frame, held until the decoder takes it or 40 clocks pass
	task automatic send(input logic [7:0] a, input logic [3:0] l,
		input logic [15:0] c, input logic [15:0] d, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge ref_clk_in);
		rx_valid_out <= 1'b1;
		rx_id_out <= {21'h000c05, a};
		rx_dlc_out <= l;
		rx_data_out <= {d, c};
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge ref_clk_in);
			ok = rx_ready_in;
		end
		// Released id and data lines carry junk so stale values cannot pass
		rx_valid_out <= 1'b0;
		rx_id_out <= ~rx_id_out;
		rx_data_out <= ~rx_data_out;
	endtask
endmodule // can_master_model
`default_nettype wire

// [verification/tb_can_command_fault_decoder.sv]
// Self-checking bench for the CAN command and fault decoder
`default_nettype none
module tb_can_command_fault_decoder;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [7:0] load_pct = 8'h00;
	logic [9:0] flags = 10'h000;
	logic restart = 1'b0;
	logic stall = 1'b0;
	wire logic rx_valid, rx_ready, tx_valid, tx_ready;
	wire logic [28:0] rx_id, tx_id;
	wire logic [3:0] rx_dlc, tx_dlc;
	wire logic [31:0] rx_data, tx_data;
	wire logic [15:0] fault_word, cc, cv, acv, acf;
	wire logic ac_on, chg_en, saving, two_stage, unlocked, pending;
	int n_mismatch = 0;
	int total_checks = 0;
	int seed = 83207;
	logic [63:0] exp_q[$];
	logic [15:0] curve_tab[3] = '{16'h0040, 16'h0041, 16'h0000};
	logic [15:0] mode_tab[4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0000};
	logic [15:0] mode_exp[4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0000};
	logic [15:0] op_tab[5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0006,
		16'h0000};
	logic [7:0] ld_tab[7] = '{8'h63, 8'h64, 8'h72, 8'h73, 8'h95, 8'h96,
		8'hff};
	logic [15:0] vals[2] = '{16'h00e6, 16'h0032};
	logic [31:0] act = 32'h0;

	can_command_fault_decoder u_dut (.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in), .unit_addr_in(8'h01),
		.rx_valid_in(rx_valid), .rx_id_in(rx_id), .rx_dlc_in(rx_dlc),
		.rx_data_in(rx_data), .rx_ready_out(rx_ready),
		.tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
		.tx_id_out(tx_id), .tx_dlc_out(tx_dlc), .tx_data_out(tx_data),
		.load_pct_in(load_pct), .fault_flags_in(flags),
		.restart_in(restart), .fault_status_word_out(fault_word),
		.ac_output_on_out(ac_on), .charger_enable_out(chg_en),
		.energy_saving_out(saving), .two_stage_charge_out(two_stage),
		.charge_current_out(cc), .charge_voltage_out(cv),
		.output_voltage_out(acv), .output_frequency_out(acf),
		.settings_unlocked_out(unlocked), .restart_pending_out(pending));

	can_master_model u_master (.ref_clk_in(ref_clk_in),
		.rx_ready_in(rx_ready), .stall_in(stall), .rx_valid_out(rx_valid),
		.rx_id_out(rx_id), .rx_dlc_out(rx_dlc), .rx_data_out(rx_data),
		.tx_ready_out(tx_ready));

	////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	always #5 ref_clk_in = ~ref_clk_in;

	// Random reply stalls, short enough for the bounded waits
	always @(posedge ref_clk_in) begin
		stall <= ($random(seed) % 3) == 0;
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic hang();
		n_mismatch++;
		tally_and_finish();
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] c,
		input logic [15:0] d, input logic [3:0] l = 4'h4);
		bit ok;
		u_master.send(a, l, c, d, ok);
		if (!ok)
			hang();
	endtask

	// Read request; the reply is noted first, then awaited under a bound
	task automatic rd(input logic [15:0] c, input logic [15:0] d);
		int n;
		exp_q.push_back({3'h0, 21'h000c04, 8'h01, d, c});
		wr(8'h01, c, ~c, 4'h2);
		// Receiver must hold off while the reply still waits for the framer
		#1;
		check(rx_ready, 1'b0);
		for (n = 0; n < 60 && exp_q.size() > 0; n++)
			@(posedge ref_clk_in);
		if (exp_q.size() > 0)
			hang();
	endtask

	task automatic settle();
		repeat (4) @(posedge ref_clk_in);
		#1;
	endtask

	// Expected fault word from condition inputs and load bands
	function automatic logic [15:0] fexp(input logic [7:0] l,
		input logic [9:0] f);
		return {3'h0, f, l >= 8'h96, l >= 8'h73 && l < 8'h96,
			l >= 8'h64 && l < 8'h73};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reply watcher: each accepted frame takes the oldest note
	always @(posedge ref_clk_in) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (exp_q.size() == 0)
				check(64'h1, 64'h0);
			else
				check({3'h0, tx_id, tx_data}, exp_q.pop_front());
			check(tx_dlc, 4'h4);
		end
	end

	// Main sequence
	initial begin
		int i;
		repeat (12) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		settle();
		check({ac_on, chg_en, unlocked, pending}, 4'b1100);
		check(fault_word, 16'h0000);
		// Charge setpoints as 0.01 counts, then foreign and odd frames
		wr(8'h01, 16'h00b0, 16'h1388);
		wr(8'h01, 16'h00b1, 16'h15e0);
		wr(8'h00, 16'h00b0, 16'h0001);
		wr(8'h81, 16'h00b0, 16'h0002);
		wr(8'h01, 16'h00b0, 16'h0003, 4'h3);
		wr(8'h00, 16'h00b0, 16'h0000, 4'h2);
		settle();
		check({cc, cv}, 32'h138815e0);
		rd(16'h00b0, 16'h1388);
		rd(16'h00b1, 16'h15e0);
		for (i = 0; i < 3; i++) begin
			wr(8'h01, 16'h00b4, curve_tab[i]);
			settle();
			check(two_stage, curve_tab[i] == 16'h0040);
			rd(16'h00b4, curve_tab[i]);
		end
		rd(16'h0101, 16'h0000);
		for (i = 0; i < 4; i++) begin
			wr(8'h01, 16'h0101, mode_tab[i]);
			settle();
			check(saving, mode_exp[i][0]);
			rd(16'h0101, mode_exp[i]);
		end
		// Switch bit obeyed only with remote enable set
		for (i = 0; i < 5; i++) begin
			wr(8'h01, 16'h0100, op_tab[i]);
			settle();
			check({ac_on, chg_en}, {op_tab[i][1] ? op_tab[i][0] : 1'b1,
				op_tab[i][2]});
			rd(16'h0100, op_tab[i]);
		end
		// Locked write, wrong key, key, write, then restart applies it
		for (i = 0; i < 2; i++) begin
			wr(8'h01, 16'(16'h0102 + i), ~vals[i]);
			wr(8'h01, 16'h00cf, 16'h574c);
			settle();
			check({unlocked, pending}, 2'b00);
			wr(8'h01, 16'h00cf, 16'h574d);
			wr(8'h01, 16'(16'h0102 + i), vals[i]);
			settle();
			check({unlocked, pending, acv, acf}, {2'b11, act});
			rd(16'(16'h0102 + i), vals[i]);
			@(posedge ref_clk_in);
			restart <= 1'b1;
			@(posedge ref_clk_in);
			restart <= 1'b0;
			act[16 * (1 - i) +: 16] = vals[i];
			settle();
			check({unlocked, pending, acv, acf}, {2'b00, act});
		end
		// Unlock item is write-only and reads back as zero
		rd(16'h00cf, 16'h0000);
		// Fault word at band edges and with random conditions
		for (i = 0; i < 12; i++) begin
			@(posedge ref_clk_in);
			load_pct <= (i < 7) ? ld_tab[i] : 8'($random(seed));
			flags <= 10'($random(seed));
			settle();
			check(fault_word, fexp(load_pct, flags));
			if (i % 3 == 0)
				rd(16'h011e, fexp(load_pct, flags));
		end
		check(fault_word, fexp(load_pct, flags));
		tally_and_finish();
	end
endmodule // tb_can_command_fault_decoder
`default_nettype wire
